// ### include/nv_write_pkg.sv
// Notes on behaviour
// - MOVX write with address starts flash write
// - Flash write accepted only with flash enable
// - Flash byte programming stalls CPU throughout
// - Peripherals keep running while CPU stalls
// - Interrupts stay pending; serviced after write
// - Flash reads via MOVX/MOVC, no wait
// - Key sets unlock flag, other clears
// - Command register bit 0 reads unlock flag
// - Enable keys set flags, others clear both
// - Enable register bit 7 reads flash enable
// - Enable register bit 5 reads EEPROM enable
// - Timeout flag set on timeout, cleared disabled
// - Select field: off, 1, 3.9, 7.8 ms
// - EEPROM 128 bytes at even addresses only
// - EEPROM byte write stalls CPU about 1 ms
// - EEPROM shares timeout watchdog and flag
// - EEPROM read returns after 300 ns
// - Main range writes need unlock flag set
// - Byte programming needs no page erase
package nv_write_pkg;

  // Special function register addresses
  localparam logic [7:0] SOFTWARE_COMMAND_ADDR = 8'h97;
  localparam logic [7:0] WREN_ADDR  = 8'hC9;
  localparam logic [7:0] AUXILIARY_CONTROL_TWO_ADDR  = 8'hF7;

  // Key values
  localparam logic [7:0] UNLOCK_KEY    = 8'h65;
  localparam logic [7:0] FLASH_WE_KEY  = 8'h47;
  localparam logic [7:0] EEPROM_WE_KEY = 8'hE2;

  // Field positions
  localparam int WREN_FLASH_BIT  = 7;
  localparam int WREN_TO_BIT     = 6;
  localparam int WREN_EE_BIT     = 5;
  localparam int SOFTWARE_COMMAND_WATCHDOG_TIMEOUT_FLAG_BIT  = 1;
  localparam int SOFTWARE_COMMAND_UNLK_BIT  = 0;
  localparam int AUXILIARY_CONTROL_TWO_SEL_LSB    = 1;

  // Reset values
  localparam logic [7:0] AUXILIARY_CONTROL_TWO_RESET = 8'h06;

  // Address map
  localparam logic [15:0] FLASH_LAST     = 16'h3FFE;
  localparam logic [15:0] FLASH_MAIN_END = 16'h3EFF;
  localparam logic [15:0] FLASH_FREE_END = 16'h3FF7;
  localparam logic [7:0]  EE_PAGE        = 8'hEE;

  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int NS_PER_US     = 1000;
  localparam int CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;
  localparam int EE_READ_NS    = 300;
  localparam int EE_READ_CYC   = (EE_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TO_SEL1_US    = 1000;
  localparam int TO_SEL2_US    = 3900;
  localparam int TO_SEL3_US    = 7800;
  localparam int EE_PROG_US    = 1000;

  // Controller states
  typedef enum logic [1:0] {ST_IDLE, ST_FPROG, ST_EPROG, ST_EREAD} nv_state_t;

endpackage : nv_write_pkg

// ### rtl/nv_write_timer.sv
`timescale 1ns/100ps
module nv_write_timer
  import nv_write_pkg::*;
#(
  parameter int TO1_US  = TO_SEL1_US,
  parameter int TO2_US  = TO_SEL2_US,
  parameter int TO3_US  = TO_SEL3_US,
  parameter int PROG_US = EE_PROG_US
)(
  input  wire logic       clk,        // System clock
  input  wire logic       rst_n,      // Synchronised reset
  input  wire logic       run,        // Write in progress
  input  wire logic [1:0] sel,        // Timeout select
  output logic            prog_done,  // Programming time elapsed
  output logic            timeout     // Watchdog fired
);
  import nv_write_pkg::*;

  logic [4:0]  div_q;
  logic        tick;
  logic [12:0] us_q;
  logic [12:0] limit;

  // Microsecond enable divider
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= 5'h00;
    else if (!run || tick)
      div_q <= 5'h00;
    else
      div_q <= div_q + 5'h01;
  end
  assign tick = run && (div_q == 5'(CYC_PER_US - 1));

  // Elapsed microseconds of the current write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      us_q <= 13'h0000;
    else if (!run)
      us_q <= 13'h0000;
    else if (tick)
      us_q <= us_q + 13'h0001;
  end

  // Timeout limit per select code
  always_comb
  begin
    unique case (sel)
      2'b01:   limit = 13'(TO1_US);
      2'b10:   limit = 13'(TO2_US);
      2'b11:   limit = 13'(TO3_US);
      default: limit = 13'h0000;
    endcase
  end

  assign prog_done = run && (us_q >= 13'(PROG_US));
  assign timeout   = run && (sel != 2'b00) && (us_q >= limit);

endmodule : nv_write_timer

// ### rtl/nv_write_ctrl.sv
`timescale 1ns/100ps
module nv_write_ctrl
  import nv_write_pkg::*;
#(
  parameter int TO1_US  = TO_SEL1_US,  // Timeout code 01, microseconds
  parameter int TO2_US  = TO_SEL2_US,  // Timeout code 10, microseconds
  parameter int TO3_US  = TO_SEL3_US,  // Timeout code 11, microseconds
  parameter int PROG_US = EE_PROG_US   // EEPROM byte programming time
)(
  input  wire logic        core_clk,           // System clock, 25 MHz
  input  wire logic        resetn,             // Asynchronous reset, active low
  // Special function register port
  input  wire logic [7:0]  sfr_addr,           // Register address
  input  wire logic [7:0]  sfr_wdata,          // Write data
  input  wire logic        sfr_we,             // Write strobe
  input  wire logic        sfr_re,             // Read strobe
  output logic      [7:0]  sfr_rdata,          // Read data, one cycle later
  input  wire logic        watchdog_timeout_flag, // System watchdog flag
  // External data (MOVX) port
  input  wire logic [15:0] x_addr,             // DPTR value
  input  wire logic [7:0]  x_wdata,            // ACC value
  input  wire logic        x_we,               // MOVX write strobe
  input  wire logic        x_re,               // MOVX read strobe
  output logic      [7:0]  x_rdata,            // MOVX read data
  output logic             x_rvalid,           // MOVX read data valid
  // Code (MOVC) port
  input  wire logic        code_re,            // MOVC read strobe
  output logic      [7:0]  code_rdata,         // MOVC read data
  output logic             code_rvalid,        // MOVC read data valid
  // CPU stall
  output logic             cpu_wait,           // Holds the CPU core only
  // Flash array
  input  wire logic [7:0]  flash_rdata,        // Array read data at x/code address
  input  wire logic        flash_prog_ready,   // Array finished programming
  output logic             flash_prog,         // Byte programming request
  output logic      [13:0] flash_prog_addr,    // Byte address
  output logic      [7:0]  flash_prog_data,    // Byte value
  // Status
  output logic             whole_flash_unlock, // Protected sectors open
  output logic      [7:0]  auxiliary_control_two // Auxiliary register value
);
  import nv_write_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode helpers

  // Flash address writable given the unlock state
  function automatic logic flash_writable(input logic [15:0] a, input logic unlk);
    logic ok;
    ok = 1'b0;
    if (a <= FLASH_MAIN_END)
      ok = unlk;
    else if (a <= FLASH_FREE_END)
      ok = 1'b1;
    else if (a <= FLASH_LAST)
      ok = unlk;
    return ok;
  endfunction : flash_writable

  // Valid EEPROM location: even byte on its page
  function automatic logic ee_hit(input logic [15:0] a);
    return (a[15:8] == EE_PAGE) && !a[0];
  endfunction : ee_hit

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser

  logic rst_meta_q;
  logic rst_n;

  // Two-stage release of reset
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  nv_state_t   state_q;
  logic        unlock_q;
  logic        flash_we_q;
  logic        ee_we_q;
  logic        timeout_q;
  logic        last_ee_q;
  logic [7:0]  auxiliary_control_two_q;
  logic [7:0]  sfr_rdata_q;
  logic [7:0]  x_rdata_q;
  logic        x_rvalid_q;
  logic [7:0]  code_rdata_q;
  logic        code_rvalid_q;
  logic        wait_q;
  logic        prog_q;
  logic [13:0] prog_addr_q;
  logic [7:0]  prog_data_q;
  logic [6:0]  ee_idx_q;
  logic [7:0]  ee_wdata_q;
  logic [3:0]  rd_cnt_q;
  logic [7:0]  ee_mem_q [128];
  logic        run;
  logic        ee_done;
  logic        to_fire;
  logic        start_flash;
  logic        start_ee_wr;
  logic        start_ee_rd;
  logic        flash_rd;
  logic        sfr_wr_software_command;
  logic        sfr_wr_wren;
  logic        to_clear;

  ////////////////////////////////////////////////////////////////////////////
  // Request qualification

  assign sfr_wr_software_command = sfr_we && (sfr_addr == SOFTWARE_COMMAND_ADDR);
  assign sfr_wr_wren  = sfr_we && (sfr_addr == WREN_ADDR);

  // Writes are taken only while idle and enabled
  assign start_flash = (state_q == ST_IDLE) && x_we && flash_we_q
                       && flash_writable(x_addr, unlock_q);
  assign start_ee_wr = (state_q == ST_IDLE) && x_we && ee_we_q
                       && ee_hit(x_addr);
  assign start_ee_rd = (state_q == ST_IDLE) && x_re && ee_hit(x_addr);
  assign flash_rd    = (state_q == ST_IDLE) && x_re && (x_addr <= FLASH_LAST);

  assign run = (state_q == ST_FPROG) || (state_q == ST_EPROG);

  ////////////////////////////////////////////////////////////////////////////
  // Programming time and watchdog

  nv_write_timer #(
    .TO1_US  (TO1_US),
    .TO2_US  (TO2_US),
    .TO3_US  (TO3_US),
    .PROG_US (PROG_US)
  ) u_timer (
    .clk       (core_clk),
    .rst_n     (rst_n),
    .run       (run),
    .sel       (auxiliary_control_two_q[AUXILIARY_CONTROL_TWO_SEL_LSB +: 2]),
    .prog_done (ee_done),
    .timeout   (to_fire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Controller state machine

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= ST_IDLE;
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (start_flash)
            state_q <= ST_FPROG;
          else if (start_ee_wr)
            state_q <= ST_EPROG;
          else if (start_ee_rd)
            state_q <= ST_EREAD;
        end
        ST_FPROG:
        begin
          if (to_fire || flash_prog_ready)
            state_q <= ST_IDLE;
        end
        ST_EPROG:
        begin
          if (to_fire || ee_done)
            state_q <= ST_IDLE;
        end
        ST_EREAD:
        begin
          if (rd_cnt_q == 4'(EE_READ_CYC - 1))
            state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // CPU stall: only the core waits, the rest of the chip keeps its clock
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      wait_q <= 1'b0;
    else if (start_flash || start_ee_wr || start_ee_rd)
      wait_q <= 1'b1;
    else if ((state_q == ST_FPROG) && (to_fire || flash_prog_ready))
      wait_q <= 1'b0;
    else if ((state_q == ST_EPROG) && (to_fire || ee_done))
      wait_q <= 1'b0;
    else if ((state_q == ST_EREAD) && (rd_cnt_q == 4'(EE_READ_CYC - 1)))
      wait_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash programming request

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prog_q      <= 1'b0;
      prog_addr_q <= 14'h0000;
      prog_data_q <= 8'h00;
    end
    else if (start_flash)
    begin
      prog_q      <= 1'b1;
      prog_addr_q <= x_addr[13:0];
      prog_data_q <= x_wdata;
    end
    else if ((state_q == ST_FPROG) && (to_fire || flash_prog_ready))
      prog_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // EEPROM storage

  // Latch target of an EEPROM access
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ee_idx_q   <= 7'h00;
      ee_wdata_q <= 8'h00;
    end
    else if (start_ee_wr || start_ee_rd)
    begin
      ee_idx_q   <= x_addr[7:1];
      ee_wdata_q <= x_wdata;
    end
  end

  // Byte commits at the end of its programming time, not on timeout
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 128; i++)
        ee_mem_q[i] <= 8'h00;
    end
    else if ((state_q == ST_EPROG) && ee_done && !to_fire)
      ee_mem_q[ee_idx_q] <= ee_wdata_q;
  end

  // Access time counter for EEPROM reads
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_cnt_q <= 4'h0;
    else if (state_q == ST_EREAD)
      rd_cnt_q <= rd_cnt_q + 4'h1;
    else
      rd_cnt_q <= 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read paths

  // MOVX read data: flash at once, EEPROM after access time
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      x_rdata_q  <= 8'h00;
      x_rvalid_q <= 1'b0;
    end
    else if (flash_rd)
    begin
      x_rdata_q  <= flash_rdata;
      x_rvalid_q <= 1'b1;
    end
    else if ((state_q == ST_EREAD) && (rd_cnt_q == 4'(EE_READ_CYC - 1)))
    begin
      x_rdata_q  <= ee_mem_q[ee_idx_q];
      x_rvalid_q <= 1'b1;
    end
    else
      x_rvalid_q <= 1'b0;
  end

  // MOVC read data, never stalled
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      code_rdata_q  <= 8'h00;
      code_rvalid_q <= 1'b0;
    end
    else
    begin
      code_rvalid_q <= code_re;
      if (code_re)
        code_rdata_q <= flash_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  // Whole-flash unlock key
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      unlock_q <= 1'b0;
    else if (sfr_wr_software_command)
      unlock_q <= (sfr_wdata == UNLOCK_KEY);
  end

  // Write enable keys
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flash_we_q <= 1'b0;
      ee_we_q    <= 1'b0;
    end
    else if (sfr_wr_wren)
    begin
      flash_we_q <= (sfr_wdata == FLASH_WE_KEY);
      ee_we_q    <= (sfr_wdata == EEPROM_WE_KEY);
    end
  end

  // Kind of the most recent write, selects which enable clears the flag
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      last_ee_q <= 1'b0;
    else if (start_flash)
      last_ee_q <= 1'b0;
    else if (start_ee_wr)
      last_ee_q <= 1'b1;
  end

  assign to_clear = last_ee_q ? !ee_we_q : !flash_we_q;

  // Timeout flag: set wins over clear
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      timeout_q <= 1'b0;
    else if (to_fire)
      timeout_q <= 1'b1;
    else if (to_clear)
      timeout_q <= 1'b0;
  end

  // Auxiliary control register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      auxiliary_control_two_q <= AUXILIARY_CONTROL_TWO_RESET;
    else if (sfr_we && (sfr_addr == AUXILIARY_CONTROL_TWO_ADDR))
      auxiliary_control_two_q <= sfr_wdata;
  end

  // Register read-back
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      sfr_rdata_q <= 8'h00;
    else if (sfr_re)
    begin
      sfr_rdata_q <= 8'h00;
      unique case (sfr_addr)
        SOFTWARE_COMMAND_ADDR:
        begin
          sfr_rdata_q[SOFTWARE_COMMAND_UNLK_BIT] <= unlock_q;
          sfr_rdata_q[SOFTWARE_COMMAND_WATCHDOG_TIMEOUT_FLAG_BIT] <= watchdog_timeout_flag;
        end
        WREN_ADDR:
        begin
          sfr_rdata_q[WREN_FLASH_BIT] <= flash_we_q;
          sfr_rdata_q[WREN_TO_BIT]    <= timeout_q;
          sfr_rdata_q[WREN_EE_BIT]    <= ee_we_q;
        end
        AUXILIARY_CONTROL_TWO_ADDR:
          sfr_rdata_q <= auxiliary_control_two_q;
        default:
          sfr_rdata_q <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign sfr_rdata             = sfr_rdata_q;
  assign x_rdata               = x_rdata_q;
  assign x_rvalid              = x_rvalid_q;
  assign code_rdata            = code_rdata_q;
  assign code_rvalid           = code_rvalid_q;
  assign cpu_wait              = wait_q;
  assign flash_prog            = prog_q;
  assign flash_prog_addr       = prog_addr_q;
  assign flash_prog_data       = prog_data_q;
  assign whole_flash_unlock    = unlock_q;
  assign auxiliary_control_two = auxiliary_control_two_q;

endmodule : nv_write_ctrl

// ### bench/nv_write_ctrl_monitor.sv
`timescale 1ns/100ps
module nv_write_ctrl_monitor
  import nv_write_pkg::*;
#(
  parameter int TO1_US  = TO_SEL1_US,
  parameter int TO2_US  = TO_SEL2_US,
  parameter int TO3_US  = TO_SEL3_US,
  parameter int PROG_US = EE_PROG_US
)(
  input wire logic        core_clk,              // System clock
  input wire logic        resetn,                // Reset, active low
  input wire logic [7:0]  sfr_addr,              // Register address
  input wire logic [7:0]  sfr_wdata,             // Register write data
  input wire logic        sfr_we,                // Register write strobe
  input wire logic [15:0] x_addr,                // Data pointer
  input wire logic        x_we,                  // Data write strobe
  input wire logic        x_re,                  // Data read strobe
  input wire logic        x_rvalid,              // Data read valid
  input wire logic        code_re,               // Code read strobe
  input wire logic [7:0]  code_rdata,            // Code read data
  input wire logic        code_rvalid,           // Code read valid
  input wire logic        cpu_wait,              // Core stall
  input wire logic [7:0]  flash_rdata,           // Array read data
  input wire logic        flash_prog_ready,      // Array done
  input wire logic        flash_prog,            // Programming request
  input wire logic [13:0] flash_prog_addr,       // Programming address
  input wire logic [7:0]  flash_prog_data,       // Programming data
  input wire logic        whole_flash_unlock,    // Unlock flag
  input wire logic [7:0]  auxiliary_control_two  // Auxiliary register
);
  logic [15:0] wait_q;
  logic [15:0] lim;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////////
  // Length of the current stall
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      wait_q <= 16'h0000;
    else if (cpu_wait)
      wait_q <= wait_q + 16'h0001;
    else
      wait_q <= 16'h0000;

  // Longest stall the selected watchdog allows
  always_comb
    case (auxiliary_control_two[2:1])
      2'b01:   lim = 16'(TO1_US * 25 + 4);
      2'b10:   lim = 16'(TO2_US * 25 + 4);
      default: lim = 16'(TO3_US * 25 + 4);
    endcase

  ////////////////////////////////////////////////////////////////////////////////
  a_prog_stalls: assert property (flash_prog |-> cpu_wait)
    else $error("programming without stall");
  a_ready_ends: assert property (flash_prog && flash_prog_ready |=> !flash_prog && !cpu_wait)
    else $error("stall outlives array ready");
  a_prog_stable: assert property (flash_prog && $past(flash_prog) |->
    $stable(flash_prog_addr) && $stable(flash_prog_data))
    else $error("programming address or data moved");
  a_flash_read: assert property (x_re && !cpu_wait && x_addr <= FLASH_LAST |=>
    x_rvalid && !cpu_wait)
    else $error("flash read not answered next cycle");
  a_code_read: assert property (code_re |=> code_rvalid && code_rdata == $past(flash_rdata))
    else $error("code read wrong");
  a_ee_read: assert property (x_re && !cpu_wait && x_addr[15:8] == EE_PAGE && !x_addr[0]
    |=> cpu_wait [*8] ##1 (x_rvalid && !cpu_wait))
    else $error("eeprom read timing wrong");
  a_odd_ee: assert property (x_re && !cpu_wait && x_addr[15:8] == EE_PAGE && x_addr[0]
    |=> !x_rvalid && !cpu_wait)
    else $error("odd eeprom address answered");
  a_stall_cause: assert property ($rose(cpu_wait) |-> $past(x_we || x_re))
    else $error("stall without access");
  a_wait_bound: assert property (auxiliary_control_two[2:1] != 2'b00 |-> wait_q <= lim)
    else $error("stall outlives watchdog");
  a_unlock_key: assert property (sfr_we && sfr_addr == SOFTWARE_COMMAND_ADDR |=>
    whole_flash_unlock == ($past(sfr_wdata) == UNLOCK_KEY))
    else $error("unlock flag wrong after command");
endmodule : nv_write_ctrl_monitor

bind nv_write_ctrl nv_write_ctrl_monitor #(.TO1_US(TO1_US), .TO2_US(TO2_US), .TO3_US(TO3_US),
  .PROG_US(PROG_US)) i_nv_write_ctrl_monitor (.core_clk, .resetn, .sfr_addr, .sfr_wdata,
  .sfr_we, .x_addr, .x_we, .x_re, .x_rvalid, .code_re, .code_rdata, .code_rvalid, .cpu_wait,
  .flash_rdata, .flash_prog_ready, .flash_prog, .flash_prog_addr, .flash_prog_data,
  .whole_flash_unlock, .auxiliary_control_two);

// ### bench/flash_array_model.sv
`timescale 1ns/100ps
module flash_array_model (
  input  wire logic        clk,        // System clock
  input  wire logic [9:0]  delay_cyc,  // Cycles until byte is programmed
  input  wire logic        prog,       // Programming request
  input  wire logic [13:0] prog_addr,  // Byte address
  input  wire logic [7:0]  prog_data,  // Byte value
  input  wire logic [13:0] rd_addr,    // Read address
  output logic      [7:0]  rdata,      // Read data
  output logic             ready       // Byte programmed
);
  logic [7:0] mem_q [16384];
  logic [9:0] cnt_q;

  // Erased array at start
  initial
  begin
    foreach (mem_q[i]) mem_q[i] = 8'hFF;
    cnt_q = 10'h000;
    ready = 1'b0;
  end

  // Byte programming, no erase step, slow when delay is long
  always @(posedge clk)
    if (prog && !ready)
    begin
      cnt_q <= cnt_q + 10'h001;
      if (cnt_q == delay_cyc)
      begin
        mem_q[prog_addr] <= prog_data;
        ready            <= 1'b1;
      end
    end
    else
    begin
      cnt_q <= 10'h000;
      ready <= 1'b0;
    end

  assign rdata = mem_q[rd_addr];
endmodule : flash_array_model

// ### bench/tb_nv_write_ctrl.sv
`timescale 1ns/100ps
module tb_nv_write_ctrl;
  import nv_write_pkg::*;
  localparam int TICK = 25;
  localparam int T1   = 2;
  localparam int T2   = 4;
  localparam int T3   = 6;
  localparam int PU   = 3;
  logic        core_clk  = 1'b0;
  logic        resetn    = 1'b0;
  logic [7:0]  sfr_addr  = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        sfr_we    = 1'b0;
  logic        sfr_re    = 1'b0;
  logic        wdt_flag  = 1'b0;
  logic [15:0] x_addr    = 16'h0000;
  logic [7:0]  x_wdata   = 8'h00;
  logic        x_we      = 1'b0;
  logic        x_re      = 1'b0;
  logic        code_re   = 1'b0;
  logic [9:0]  delay_cyc = 10'd40;
  logic [7:0]  sfr_rdata, x_rdata, code_rdata, flash_rdata, prog_data, aux_val;
  logic        x_rvalid, code_rvalid, cpu_wait, prog_ready, flash_prog, unlock;
  logic [13:0] prog_addr;
  int          bad_count = 0;
  int          checks    = 0;
  int          waited;
  int          tos [3]   = '{T1, T2, T3};

  always #20 core_clk = ~core_clk;

  nv_write_ctrl #(.TO1_US(T1), .TO2_US(T2), .TO3_US(T3), .PROG_US(PU)) i_nv_write_ctrl (
    .core_clk(core_clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata), .watchdog_timeout_flag(wdt_flag),
    .x_addr(x_addr), .x_wdata(x_wdata), .x_we(x_we), .x_re(x_re), .x_rdata(x_rdata),
    .x_rvalid(x_rvalid), .code_re(code_re), .code_rdata(code_rdata),
    .code_rvalid(code_rvalid), .cpu_wait(cpu_wait), .flash_rdata(flash_rdata),
    .flash_prog_ready(prog_ready), .flash_prog(flash_prog), .flash_prog_addr(prog_addr),
    .flash_prog_data(prog_data), .whole_flash_unlock(unlock), .auxiliary_control_two(aux_val));

  flash_array_model i_flash_array_model (.clk(core_clk), .delay_cyc(delay_cyc),
    .prog(flash_prog), .prog_addr(prog_addr), .prog_data(prog_data), .rd_addr(x_addr[13:0]),
    .rdata(flash_rdata), .ready(prog_ready));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic check_ok(input logic ok);
    check({15'h0000, ok}, 16'h0001);
  endtask : check_ok

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // Register write, strobe held over one rising edge
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_we    = 1'b1;
    @(negedge core_clk);
    sfr_we = 1'b0;
  endtask : sfr_wr

  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_re   = 1'b1;
    @(negedge core_clk);
    sfr_re = 1'b0;
    check({8'h00, sfr_rdata}, {8'h00, exp});
  endtask : sfr_rd

  // Data write, then count stalled cycles
  task automatic x_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    x_addr  = a;
    x_wdata = d;
    x_we    = 1'b1;
    @(negedge core_clk);
    x_we   = 1'b0;
    waited = 0;
    while (cpu_wait === 1'b1 && waited < 2000)
    begin
      @(negedge core_clk);
      waited++;
    end
  endtask : x_wr

  // Data read; cycles until valid, 20 means no answer
  task automatic x_rd(input logic [15:0] a, input logic [7:0] exp, input int cyc);
    int n;
    @(negedge core_clk);
    x_addr = a;
    x_re   = 1'b1;
    @(negedge core_clk);
    x_re = 1'b0;
    n    = 1;
    while (x_rvalid !== 1'b1 && n < 20)
    begin
      @(negedge core_clk);
      n++;
    end
    check(n[15:0], cyc[15:0]);
    if (cyc < 20)
      check({8'h00, x_rdata}, {8'h00, exp});
  endtask : x_rd

  task automatic code_rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    x_addr  = a;
    code_re = 1'b1;
    @(negedge core_clk);
    code_re = 1'b0;
    check({8'h00, code_rdata}, {8'h00, exp});
  endtask : code_rd

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hang
  initial
  begin
    #400000;
    bad_count++;
    print_verdict();
  end

  // Main sequence
  initial
  begin
    repeat (20) @(negedge core_clk);
    resetn = 1'b1;
    repeat (3) @(negedge core_clk);
    check({8'h00, aux_val}, 16'h0006);
    sfr_rd(8'hF7, 8'h06);
    sfr_rd(8'hC9, 8'h00);
    sfr_rd(8'h97, 8'h00);
    sfr_rd(8'h90, 8'h00);
    sfr_wr(8'hC9, FLASH_WE_KEY);
    sfr_rd(8'hC9, 8'h80);
    sfr_wr(8'hC9, EEPROM_WE_KEY);
    sfr_rd(8'hC9, 8'h20);
    sfr_wr(8'hC9, 8'h13);
    sfr_rd(8'hC9, 8'h00);
    sfr_wr(8'h97, UNLOCK_KEY);
    sfr_rd(8'h97, 8'h01);
    sfr_wr(8'h97, 8'h64);
    wdt_flag = 1'b1;
    sfr_rd(8'h97, 8'h02);
    wdt_flag = 1'b0;
    // Disabled write, then byte writes without erase
    sfr_wr(8'hF7, 8'h00);
    x_wr(16'h3F00, 8'h5A);
    check(waited[15:0], 16'h0000);
    x_rd(16'h3F00, 8'hFF, 1);
    for (int i = 0; i < 2; i++)
    begin
      sfr_wr(8'hC9, FLASH_WE_KEY);
      x_wr(16'h3F00, 8'h5A ^ {8{i[0]}});
      check_ok(waited >= 40 && waited <= 45);
      sfr_wr(8'hC9, 8'h00);
      x_rd(16'h3F00, 8'h5A ^ {8{i[0]}}, 1);
      code_rd(16'h3F00, 8'h5A ^ {8{i[0]}});
    end
    // Main range needs the unlock flag
    sfr_wr(8'hC9, FLASH_WE_KEY);
    x_wr(16'h0100, 8'h33);
    check(waited[15:0], 16'h0000);
    sfr_wr(8'h97, UNLOCK_KEY);
    x_wr(16'h0100, 8'h33);
    check_ok(waited >= 40);
    sfr_wr(8'h97, 8'h00);
    sfr_wr(8'hC9, 8'h00);
    x_rd(16'h0100, 8'h33, 1);
    // EEPROM write and reads
    sfr_wr(8'hC9, EEPROM_WE_KEY);
    x_wr(16'hEE02, 8'hA5);
    check_ok(waited >= PU * TICK && waited <= PU * TICK + 5);
    sfr_wr(8'hC9, 8'h00);
    x_rd(16'hEE02, 8'hA5, EE_READ_CYC + 1);
    x_rd(16'hEE03, 8'h00, 20);
    sfr_wr(8'hC9, FLASH_WE_KEY);
    x_wr(16'hEE04, 8'h11);
    check(waited[15:0], 16'h0000);
    // Watchdog codes against a slow array
    delay_cyc = 10'd300;
    for (int k = 1; k < 4; k++)
    begin
      sfr_wr(8'hF7, 8'(k << AUXILIARY_CONTROL_TWO_SEL_LSB));
      sfr_wr(8'hC9, FLASH_WE_KEY);
      x_wr(16'h3F10, 8'(k));
      check_ok(waited >= (tos[k-1] - 1) * TICK && waited <= tos[k-1] * TICK + 4);
      check({15'h0000, flash_prog}, 16'h0000);
      sfr_rd(8'hC9, 8'hC0);
      sfr_wr(8'hC9, 8'h00);
      sfr_rd(8'hC9, 8'h00);
    end
    sfr_wr(8'hF7, 8'h00);
    sfr_wr(8'hC9, FLASH_WE_KEY);
    x_wr(16'h3F11, 8'h44);
    check_ok(waited >= 300);
    sfr_rd(8'hC9, 8'h80);
    // EEPROM shares the watchdog and flag
    sfr_wr(8'hF7, 8'h02);
    sfr_wr(8'hC9, EEPROM_WE_KEY);
    x_wr(16'hEE06, 8'h77);
    check_ok(waited >= (T1 - 1) * TICK && waited <= T1 * TICK + 4);
    sfr_rd(8'hC9, 8'h60);
    sfr_wr(8'hC9, 8'h00);
    sfr_rd(8'hC9, 8'h00);
    print_verdict();
  end
endmodule : tb_nv_write_ctrl
